/* design/tme_defines.svh */
// Constants for the tile matrix engine: offsets, bit positions and timing counts.
`ifndef TME_DEFINES_SVH
`define TME_DEFINES_SVH
`define TME_LEAF_EXT 32'h0000_0007
`define TME_LEAF_BASIC 32'h0000_0001
`define TME_SUBLEAF_0 32'h0000_0000
`define TME_DATA_BIT_A 22
`define TME_DATA_BIT_B 24
`define TME_DATA_BIT_C 25
`define TME_COUNT_BIT_XR 26
`define TME_XCR_IDX_0 32'h0000_0000
`define TME_XCR_BIT_A 17
`define TME_XCR_BIT_B 18
`define TME_MAX_ROWS 5'h10
`define TME_MAX_COLB 7'h40
`define TME_PACK_BYTES 7'h04
`define TME_CLK_MHZ 100
`define TME_CYC(c) ((c) * `TME_CLK_MHZ / 100)
`define TME_LAT_LDCFG 204
`define TME_LAT_STCFG 19
`define TME_LAT_REL 13
`define TME_LAT_MUL 52
`define TME_THR_MUL 16
`define TME_LAT_LD 45
`define TME_THR_LD 8
`define TME_LAT_LDNT 48
`define TME_THR_LDNT 33
`define TME_THR_ST 16
`define TME_LAT_ZERO 16
`endif

/* design/tme_pkg.sv */
// Types shared by the tile matrix engine modules.
package tme_pkg;
   typedef enum logic [3:0] {
      OP_LOAD_CFG = 4'h0, OP_STORE_CFG = 4'h1, OP_RELEASE = 4'h2, OP_LOAD = 4'h3,
      OP_LOAD_NT = 4'h4, OP_STORE = 4'h5, OP_ZERO = 4'h6, OP_MUL = 4'h7
   } tme_op_t;
   typedef enum logic [2:0] {
      DT_SS = 3'h0, DT_SU = 3'h1, DT_US = 3'h2, DT_UU = 3'h3, DT_BF16 = 3'h4
   } tme_dtype_t;
   typedef struct packed {
      tme_op_t op;
      logic [2:0] dst;
      logic [2:0] src_a;
      logic [2:0] src_b;
      logic [63:0] base;
      logic [31:0] stride;
      logic [4:0] rows;
      logic [6:0] colb;
      tme_dtype_t dtype;
   } tme_cmd_t;
endpackage

/* design/tme_lat.sv */
// Down counter that holds an operation's minimum latency.
`timescale 1ns/1ps
module tme_lat #(parameter int W = 8)
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic load,
   input wire logic [W-1:0] value,
   output logic expired
);
   logic [W-1:0] cnt_r;
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         cnt_r <= '0;
      else if (load)
         cnt_r <= value;
      else if (cnt_r != '0)
         cnt_r <= cnt_r - 1'b1;
   end
   assign expired = (cnt_r <= 1);
endmodule // tme_lat

/* design/tme_mac.sv */
// One multiply-accumulate step for 8-bit integer or bfloat16 elements.
`timescale 1ns/1ps
module tme_mac import tme_pkg::*;
(
   input wire tme_dtype_t dtype,
   input wire logic [15:0] a_el,
   input wire logic [15:0] b_el,
   input wire logic [31:0] acc_in,
   output logic [31:0] acc_out
);
   logic [8:0] ai, bi;
   logic [17:0] ip;
   logic pz, ps, big_s, sml_s, rs;
   logic [9:0] pe, big_e, sml_e, re;
   logic [15:0] pm;
   logic [23:0] pman, big_m, sml_m;
   logic [24:0] sum;
   logic [7:0] sh;
   always_comb
   begin
      ai = {(dtype == DT_SS || dtype == DT_SU) & a_el[7], a_el[7:0]};
      bi = {(dtype == DT_SS || dtype == DT_US) & b_el[7], b_el[7:0]};
      ip = 18'($signed(ai) * $signed(bi));
      pz = (a_el[14:7] == 8'h00) || (b_el[14:7] == 8'h00);
      ps = a_el[15] ^ b_el[15];
      pm = {1'b1, a_el[6:0]} * {1'b1, b_el[6:0]};
      pe = {2'h0, a_el[14:7]} + {2'h0, b_el[14:7]} - 10'h07f + {9'h0, pm[15]};
      pman = pm[15] ? {pm, 8'h00} : {pm[14:0], 9'h000};
      if (pz || acc_in[30:23] != 8'h00 && {2'h0, acc_in[30:23]} > pe)
      begin
         big_s = acc_in[31];
         big_e = {2'h0, acc_in[30:23]};
         big_m = (acc_in[30:23] == 8'h00) ? 24'h0 : {1'b1, acc_in[22:0]};
         sml_s = ps;
         sml_e = pz ? 10'h0 : pe;
         sml_m = pz ? 24'h0 : pman;
      end
      else
      begin
         big_s = ps;
         big_e = pe;
         big_m = pman;
         sml_s = acc_in[31];
         sml_e = {2'h0, acc_in[30:23]};
         sml_m = (acc_in[30:23] == 8'h00) ? 24'h0 : {1'b1, acc_in[22:0]};
      end
      sh = (big_e - sml_e > 10'd24) ? 8'd25 : 8'(big_e - sml_e);
      sml_m = 24'(sml_m >> sh);
      rs = big_s;
      if (big_s == sml_s)
         sum = {1'b0, big_m} + {1'b0, sml_m};
      else if (big_m >= sml_m)
         sum = {1'b0, big_m - sml_m};
      else
      begin
         sum = {1'b0, sml_m - big_m};
         rs = sml_s;
      end
      re = big_e;
      if (sum[24])
      begin
         sum = sum >> 1;
         re = re + 10'h1;
      end
      for (int i = 0; i < 24; i++)
         if (!sum[23] && sum != 25'h0)
         begin
            sum = sum << 1;
            re = re - 10'h1;
         end
      if (dtype != DT_BF16)
         acc_out = acc_in + {{14{ip[17]}}, ip};
      else if (sum == 25'h0 || re[9] || re == 10'h0)
         acc_out = 32'h0;
      else
         acc_out = {rs, re[7:0], sum[22:0]};
   end
endmodule // tme_mac

/* design/tme_top.sv */
// Tile matrix engine: tile registers, load, store, zero, multiply and capability report.
`timescale 1ns/1ps
`include "tme_defines.svh"
module tme_top import tme_pkg::*; #(
   parameter int NT = 8,
   parameter logic TILE_SUPPORTED = 1'b1
)
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic cmd_valid,
   input wire tme_cmd_t cmd,
   output logic cmd_ready_r,
   output logic rsp_done_r,
   output logic rsp_err_r,
   output logic [4:0] rsp_rows_r,
   output logic [6:0] rsp_colb_r,
   input wire logic cap_req,
   input wire logic [31:0] cap_leaf,
   input wire logic [31:0] cap_subleaf,
   output logic cap_valid_r,
   output logic [31:0] cap_data_reg_r,
   output logic [31:0] cap_count_reg_r,
   input wire logic xcr_rd_req,
   input wire logic [31:0] xcr_index,
   input wire logic xcr_wr_req,
   input wire logic [1:0] xcr_wr_bits,
   output logic xcr_valid_r,
   output logic [31:0] xcr_acc_r,
   output logic mem_rd_r,
   output logic mem_wr_r,
   output logic [63:0] mem_addr_r,
   output logic [511:0] mem_wdata_r,
   output logic [63:0] mem_wbe_r,
   input wire logic mem_rvalid,
   input wire logic [511:0] mem_rdata
);
   typedef enum logic [5:0] {
      S_IDLE = 6'b000001, S_LDREQ = 6'b000010, S_LDWAIT = 6'b000100,
      S_STORE = 6'b001000, S_MUL = 6'b010000, S_WAIT = 6'b100000
   } tme_state_t;

   tme_state_t state_r;
   tme_cmd_t cur_r;
   logic [511:0] tile_q [NT*16];
   logic [4:0] cfg_rows_r [NT];
   logic [6:0] cfg_colb_r [NT];
   logic [1:0] xcr0_r;
   logic [4:0] row_r;
   logic [3:0] m_r, n_r;
   logic [6:0] kb_r;
   logic [6:0] es;
   logic err_now, lat_exp, lat_load, cmd_go;
   logic [7:0] lat_val;
   logic [511:0] a_row, b_row, c_row;
   logic [15:0] a_el, b_el;
   logic [31:0] acc_in, acc_out;
   logic [5:0] b_idx;
   logic [6:0] b_byte;
   logic [63:0] colmask;

   function automatic logic [63:0] byte_mask(input logic [6:0] n);
      logic [64:0] one;
      one = 65'h1 << n;
      return 64'(one - 65'h1);
   endfunction

   function automatic logic [511:0] bits_of(input logic [63:0] m);
      logic [511:0] r;
      r = '0;
      for (int i = 0; i < 64; i++)
         r[i*8 +: 8] = {8{m[i]}};
      return r;
   endfunction

   assign es = (cmd.dtype == DT_BF16) ? 7'h2 : 7'h1;

   always_comb
   begin
      err_now = 1'b0;
      if (cmd.op != OP_STORE_CFG && xcr0_r != 2'b11)
         err_now = 1'b1;
      unique case (cmd.op)
         OP_LOAD_CFG:
            if (cmd.rows == 5'h0 || cmd.rows > `TME_MAX_ROWS || cmd.colb == 7'h0
                || cmd.colb > `TME_MAX_COLB)
               err_now = 1'b1;
         OP_LOAD, OP_LOAD_NT, OP_STORE, OP_ZERO:
            if (cfg_rows_r[cmd.dst] == 5'h0)
               err_now = 1'b1;
         OP_MUL:
         begin
            if (cfg_rows_r[cmd.src_a] == 5'h0 || cfg_colb_r[cmd.src_a] % es != 7'h0)
               err_now = 1'b1;
            if (cfg_rows_r[cmd.src_b] * `TME_PACK_BYTES != {2'h0, cfg_colb_r[cmd.src_a]})
               err_now = 1'b1;
            if (cfg_colb_r[cmd.src_b] != cfg_colb_r[cmd.dst]
                || cfg_colb_r[cmd.dst][1:0] != 2'h0)
               err_now = 1'b1;
            if (cfg_rows_r[cmd.dst] != cfg_rows_r[cmd.src_a] || cfg_rows_r[cmd.dst] == 5'h0)
               err_now = 1'b1;
            if (cmd.dtype > DT_BF16)
               err_now = 1'b1;
         end
         default:
         begin
         end
      endcase
   end

   always_comb
   begin
      unique case (cmd.op)
         OP_LOAD_CFG: lat_val = 8'(`TME_CYC(`TME_LAT_LDCFG));
         OP_STORE_CFG: lat_val = 8'(`TME_CYC(`TME_LAT_STCFG));
         OP_RELEASE: lat_val = 8'(`TME_CYC(`TME_LAT_REL));
         OP_MUL: lat_val = 8'(`TME_CYC(`TME_LAT_MUL));
         OP_LOAD: lat_val = 8'(`TME_CYC(`TME_LAT_LD));
         OP_LOAD_NT: lat_val = 8'(`TME_CYC(`TME_LAT_LDNT));
         OP_STORE: lat_val = 8'(`TME_CYC(`TME_THR_ST));
         OP_ZERO: lat_val = 8'(`TME_CYC(`TME_LAT_ZERO));
         default: lat_val = 8'h1;
      endcase
   end

   // A request still held while its answer stands is not taken a second time.
   assign cmd_go = cmd_valid && !rsp_done_r;
   assign lat_load = (state_r == S_IDLE) && cmd_go && !err_now;

   tme_lat #(.W(8)) u_lat
   (
      .clock(clock),
      .rst_n(rst_n),
      .load(lat_load),
      .value(lat_val),
      .expired(lat_exp)
   );

   always_comb
   begin
      a_row = tile_q[{cur_r.src_a, m_r}];
      b_idx = 6'(kb_r >> 2);
      b_row = tile_q[{cur_r.src_b, b_idx[3:0]}];
      c_row = tile_q[{cur_r.dst, m_r}];
      b_byte = {1'b0, n_r, 2'h0} + {5'h0, kb_r[1:0]};
      a_el = a_row[kb_r*8 +: 16];
      b_el = b_row[b_byte*8 +: 16];
      acc_in = c_row[n_r*32 +: 32];
      colmask = byte_mask(cfg_colb_r[cur_r.dst]);
   end

   tme_mac u_mac
   (
      .dtype(cur_r.dtype),
      .a_el(a_el),
      .b_el(b_el),
      .acc_in(acc_in),
      .acc_out(acc_out)
   );

   // Sequencer for accepted commands.
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         state_r <= S_IDLE;
         cur_r <= '0;
         row_r <= 5'h0;
         m_r <= 4'h0;
         n_r <= 4'h0;
         kb_r <= 7'h0;
      end
      else
      begin
         unique case (state_r)
            S_IDLE:
               if (cmd_go && !err_now)
               begin
                  cur_r <= cmd;
                  row_r <= 5'h0;
                  m_r <= 4'h0;
                  n_r <= 4'h0;
                  kb_r <= 7'h0;
                  unique case (cmd.op)
                     OP_LOAD, OP_LOAD_NT: state_r <= S_LDREQ;
                     OP_STORE: state_r <= S_STORE;
                     OP_MUL: state_r <= S_MUL;
                     default: state_r <= S_WAIT;
                  endcase
               end
            S_LDREQ:
               state_r <= S_LDWAIT;
            S_LDWAIT:
               if (mem_rvalid)
               begin
                  row_r <= row_r + 5'h1;
                  state_r <= (row_r + 5'h1 == cfg_rows_r[cur_r.dst]) ? S_WAIT : S_LDREQ;
               end
            S_STORE:
            begin
               row_r <= row_r + 5'h1;
               if (row_r + 5'h1 == cfg_rows_r[cur_r.dst])
                  state_r <= S_WAIT;
            end
            S_MUL:
            begin
               kb_r <= kb_r + (cur_r.dtype == DT_BF16 ? 7'h2 : 7'h1);
               if (kb_r + (cur_r.dtype == DT_BF16 ? 7'h2 : 7'h1) >= cfg_colb_r[cur_r.src_a])
               begin
                  kb_r <= 7'h0;
                  n_r <= n_r + 4'h1;
                  if ({1'b0, n_r, 2'h0} + 7'h4 >= cfg_colb_r[cur_r.dst])
                  begin
                     n_r <= 4'h0;
                     m_r <= m_r + 4'h1;
                     if ({1'b0, m_r} + 5'h1 == cfg_rows_r[cur_r.dst])
                        state_r <= S_WAIT;
                  end
               end
            end
            S_WAIT:
               if (lat_exp)
                  state_r <= S_IDLE;
            default:
               state_r <= S_IDLE;
         endcase
      end
   end

   // Tile register contents.
   always_ff @(posedge clock)
   begin
      if (state_r == S_LDWAIT && mem_rvalid)
         tile_q[{cur_r.dst, row_r[3:0]}] <= mem_rdata & bits_of(colmask);
      else if (state_r == S_IDLE && cmd_go && !err_now && cmd.op == OP_ZERO)
      begin
         for (int r = 0; r < 16; r++)
            tile_q[{cmd.dst, 4'(r)}] <= '0;
      end
      else if (state_r == S_MUL)
         tile_q[{cur_r.dst, m_r}][n_r*32 +: 32] <= acc_out;
   end

   // Tile shape configuration.
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         for (int t = 0; t < NT; t++)
         begin
            cfg_rows_r[t] <= 5'h0;
            cfg_colb_r[t] <= 7'h0;
         end
      end
      else if (state_r == S_IDLE && cmd_go && !err_now)
      begin
         if (cmd.op == OP_LOAD_CFG)
         begin
            cfg_rows_r[cmd.dst] <= cmd.rows;
            cfg_colb_r[cmd.dst] <= cmd.colb;
         end
         else if (cmd.op == OP_RELEASE)
         begin
            for (int t = 0; t < NT; t++)
            begin
               cfg_rows_r[t] <= 5'h0;
               cfg_colb_r[t] <= 7'h0;
            end
         end
      end
   end

   // Memory row read and write requests.
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         mem_rd_r <= 1'b0;
         mem_wr_r <= 1'b0;
         mem_addr_r <= 64'h0;
         mem_wdata_r <= '0;
         mem_wbe_r <= 64'h0;
      end
      else
      begin
         mem_rd_r <= (state_r == S_LDREQ);
         mem_wr_r <= (state_r == S_STORE);
         mem_addr_r <= cur_r.base + 64'(row_r) * 64'(cur_r.stride);
         mem_wdata_r <= tile_q[{cur_r.dst, row_r[3:0]}] & bits_of(colmask);
         mem_wbe_r <= (state_r == S_STORE) ? colmask : 64'h0;
      end
   end

   // Command handshake and completion.
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         cmd_ready_r <= 1'b0;
         rsp_done_r <= 1'b0;
         rsp_err_r <= 1'b0;
         rsp_rows_r <= 5'h0;
         rsp_colb_r <= 7'h0;
      end
      else
      begin
         cmd_ready_r <= (state_r == S_IDLE) && !cmd_go || (state_r == S_WAIT) && lat_exp;
         rsp_done_r <= (state_r == S_WAIT) && lat_exp || (state_r == S_IDLE) && cmd_go
                       && err_now;
         rsp_err_r <= (state_r == S_IDLE) && cmd_go && err_now;
         if (state_r == S_IDLE && cmd_go && cmd.op == OP_STORE_CFG)
         begin
            rsp_rows_r <= cfg_rows_r[cmd.dst];
            rsp_colb_r <= cfg_colb_r[cmd.dst];
         end
      end
   end

   // Capability query and extended control register access.
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         cap_valid_r <= 1'b0;
         cap_data_reg_r <= 32'h0;
         cap_count_reg_r <= 32'h0;
         xcr_valid_r <= 1'b0;
         xcr_acc_r <= 32'h0;
         xcr0_r <= 2'b00;
      end
      else
      begin
         cap_valid_r <= cap_req;
         if (cap_req)
         begin
            cap_data_reg_r <= 32'h0;
            cap_count_reg_r <= 32'h0;
            if (cap_leaf == `TME_LEAF_EXT && cap_subleaf == `TME_SUBLEAF_0)
            begin
               cap_data_reg_r[`TME_DATA_BIT_A] <= TILE_SUPPORTED;
               cap_data_reg_r[`TME_DATA_BIT_B] <= TILE_SUPPORTED;
               cap_data_reg_r[`TME_DATA_BIT_C] <= TILE_SUPPORTED;
            end
            if (cap_leaf == `TME_LEAF_BASIC)
               cap_count_reg_r[`TME_COUNT_BIT_XR] <= 1'b1;
         end
         if (xcr_wr_req)
            xcr0_r <= xcr_wr_bits;
         xcr_valid_r <= xcr_rd_req;
         if (xcr_rd_req)
         begin
            xcr_acc_r <= 32'h0;
            if (xcr_index == `TME_XCR_IDX_0)
            begin
               xcr_acc_r[`TME_XCR_BIT_A] <= xcr0_r[0];
               xcr_acc_r[`TME_XCR_BIT_B] <= xcr0_r[1];
            end
         end
      end
   end
endmodule // tme_top

/* sim/tme_top_monitor.sv */
// Concurrent checks on the tile matrix engine ports.
`timescale 1ns/1ps
`include "tme_defines.svh"
module tme_top_monitor import tme_pkg::*; #(
   parameter int NT = 8,
   parameter logic TILE_SUPPORTED = 1'b1
)
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic cmd_valid,
   input wire tme_cmd_t cmd,
   input wire logic cmd_ready_r,
   input wire logic rsp_done_r,
   input wire logic rsp_err_r,
   input wire logic cap_req,
   input wire logic [31:0] cap_leaf,
   input wire logic [31:0] cap_subleaf,
   input wire logic cap_valid_r,
   input wire logic [31:0] cap_data_reg_r,
   input wire logic [31:0] cap_count_reg_r,
   input wire logic xcr_rd_req,
   input wire logic [31:0] xcr_index,
   input wire logic xcr_wr_req,
   input wire logic [1:0] xcr_wr_bits,
   input wire logic [31:0] xcr_acc_r,
   input wire logic mem_rd_r,
   input wire logic mem_wr_r,
   input wire logic [63:0] mem_addr_r
);
   logic [1:0] en_r;
   logic take;
   tme_op_t op_r;
   logic [15:0] cyc_r;
   logic [63:0] addr_r;
   logic [31:0] stride_r;
   assign take = cmd_valid && cmd_ready_r && !rsp_done_r;
   function automatic int min_lat(input tme_op_t op);
      case (op)
         OP_LOAD_CFG: return `TME_LAT_LDCFG;
         OP_STORE_CFG: return `TME_LAT_STCFG;
         OP_RELEASE: return `TME_LAT_REL;
         OP_MUL: return `TME_LAT_MUL;
         OP_LOAD: return `TME_LAT_LD;
         OP_LOAD_NT: return `TME_LAT_LDNT;
         default: return `TME_THR_ST;
      endcase
   endfunction
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         en_r <= 2'h0;
      else if (xcr_wr_req)
         en_r <= xcr_wr_bits;
   end
   always_ff @(posedge clock)
   begin
      if (take)
      begin
         op_r <= cmd.op;
         cyc_r <= 16'h0;
         addr_r <= cmd.base;
         stride_r <= cmd.stride;
      end
      else
      begin
         cyc_r <= cyc_r + 16'h1;
         if (mem_rd_r || mem_wr_r)
            addr_r <= addr_r + {32'h0, stride_r};
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   sequence s_refused;
      ##[1:2] (rsp_done_r && rsp_err_r);
   endsequence
   a_cap_answer_next: assert property (cap_req |=> cap_valid_r)
      else $error("capability answer missing");
   a_cap_tile_bits: assert property (
      cap_req && cap_leaf == `TME_LEAF_EXT && cap_subleaf == 32'h0 |=>
      cap_data_reg_r[25:24] == {2{TILE_SUPPORTED}} && cap_data_reg_r[22] == TILE_SUPPORTED)
      else $error("tile support bits wrong");
   a_cap_read_bit: assert property (
      cap_req && cap_leaf == `TME_LEAF_BASIC |=> cap_count_reg_r[26])
      else $error("enable read support bit missing");
   a_xcr_enable_bits: assert property (
      xcr_rd_req && xcr_index == 32'h0 && !xcr_wr_req |=> xcr_acc_r[18:17] == $past(en_r))
      else $error("enable bits read wrong");
   a_gate_disabled: assert property (
      take && en_r != 2'h3 && cmd.op != OP_STORE_CFG |-> s_refused)
      else $error("command ran without enable");
   a_bad_shape: assert property (
      take && cmd.op == OP_LOAD_CFG && (cmd.rows == 5'h0 || cmd.rows > `TME_MAX_ROWS
      || cmd.colb == 7'h0 || cmd.colb > `TME_MAX_COLB) |-> s_refused)
      else $error("bad shape accepted");
   a_bad_dtype: assert property (
      take && cmd.op == OP_MUL && cmd.dtype > DT_BF16 |-> s_refused)
      else $error("bad element type accepted");
   a_min_latency: assert property (
      rsp_done_r && !rsp_err_r |-> int'(cyc_r) >= min_lat(op_r))
      else $error("operation finished too early");
   a_row_address: assert property (
      mem_rd_r || mem_wr_r |-> mem_addr_r == addr_r)
      else $error("row address wrong");
   a_mem_busy_only: assert property ((mem_rd_r || mem_wr_r) |-> !cmd_ready_r)
      else $error("memory traffic while idle");
endmodule // tme_top_monitor
bind tme_top tme_top_monitor #(.NT(NT), .TILE_SUPPORTED(TILE_SUPPORTED)) u_mon (
   .clock(clock), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd(cmd),
   .cmd_ready_r(cmd_ready_r), .rsp_done_r(rsp_done_r), .rsp_err_r(rsp_err_r),
   .cap_req(cap_req), .cap_leaf(cap_leaf), .cap_subleaf(cap_subleaf),
   .cap_valid_r(cap_valid_r), .cap_data_reg_r(cap_data_reg_r),
   .cap_count_reg_r(cap_count_reg_r), .xcr_rd_req(xcr_rd_req), .xcr_index(xcr_index),
   .xcr_wr_req(xcr_wr_req), .xcr_wr_bits(xcr_wr_bits), .xcr_acc_r(xcr_acc_r),
   .mem_rd_r(mem_rd_r), .mem_wr_r(mem_wr_r), .mem_addr_r(mem_addr_r));

/* sim/tme_mem_model.sv */
// Memory side model: answers row reads and records row writes.
`timescale 1ns/1ps
module tme_mem_model
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic slow,
   input wire logic mem_rd_r,
   input wire logic mem_wr_r,
   input wire logic [63:0] mem_addr_r,
   input wire logic [511:0] mem_wdata_r,
   output logic mem_rvalid,
   output logic [511:0] mem_rdata
);
   logic [2:0] wait_r;
   logic [63:0] addr_r;
   logic [63:0] wa [32];
   logic [63:0] wd [32];
   int wn;
   function automatic logic [511:0] pattern(input logic [63:0] a);
      for (int j = 0; j < 64; j++)
         pattern[8*j +: 8] = a[7:0] + 8'(j);
   endfunction
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         wait_r <= 3'h0;
         mem_rvalid <= 1'b0;
         mem_rdata <= '0;
         wn <= 0;
      end
      else
      begin
         mem_rvalid <= 1'b0;
         mem_rdata <= ~mem_rdata;
         if (mem_rd_r)
         begin
            addr_r <= mem_addr_r;
            wait_r <= slow ? 3'h4 : 3'h1;
         end
         else if (wait_r != 3'h0)
            wait_r <= wait_r - 3'h1;
         if (wait_r == 3'h1 && !mem_rd_r)
         begin
            mem_rvalid <= 1'b1;
            mem_rdata <= pattern(addr_r);
         end
         if (mem_wr_r)
         begin
            wa[wn[4:0]] <= mem_addr_r;
            wd[wn[4:0]] <= mem_wdata_r[63:0];
            wn <= wn + 1;
         end
      end
   end
endmodule // tme_mem_model

/* sim/tme_top_bench.sv */
// Self-checking bench for the tile matrix engine.
`timescale 1ns/1ps
module tme_top_bench import tme_pkg::*; ;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic cmd_valid = 1'b0;
   tme_cmd_t cmd = '0;
   logic cap_req = 1'b0;
   logic [31:0] cap_leaf = 32'h0;
   logic [31:0] cap_subleaf = 32'h0;
   logic xcr_rd_req = 1'b0;
   logic [31:0] xcr_index = 32'h0;
   logic xcr_wr_req = 1'b0;
   logic [1:0] xcr_wr_bits = 2'h0;
   logic slow = 1'b0;
   logic cmd_ready_r, rsp_done_r, rsp_err_r, cap_valid_r, xcr_valid_r;
   logic mem_rd_r, mem_wr_r, mem_rvalid;
   logic [4:0] rsp_rows_r;
   logic [6:0] rsp_colb_r;
   logic [31:0] cap_data_reg_r, cap_count_reg_r, xcr_acc_r;
   logic [63:0] mem_addr_r, mem_wbe_r;
   logic [511:0] mem_wdata_r, mem_rdata;
   int fails = 0;
   int n_compared = 0;
   int cycles = 0;
   int k;
   tme_cmd_t c;
   logic [4:0] bad_r [4] = '{5'h0, 5'h11, 5'h1, 5'h1};
   logic [6:0] bad_c [4] = '{7'h4, 7'h4, 7'h0, 7'h41};
   tme_dtype_t dts [5] = '{DT_SS, DT_SU, DT_US, DT_UU, DT_BF16};
   logic [31:0] mul_exp [5] = '{32'hffff_fc0c, 32'hffff_fe0c, 32'h0001_f60c, 32'h0001_f80c,
      32'h4793_9400};
   tme_top dut (.clock(clock), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd(cmd),
      .cmd_ready_r(cmd_ready_r), .rsp_done_r(rsp_done_r), .rsp_err_r(rsp_err_r),
      .rsp_rows_r(rsp_rows_r), .rsp_colb_r(rsp_colb_r), .cap_req(cap_req),
      .cap_leaf(cap_leaf), .cap_subleaf(cap_subleaf), .cap_valid_r(cap_valid_r),
      .cap_data_reg_r(cap_data_reg_r), .cap_count_reg_r(cap_count_reg_r),
      .xcr_rd_req(xcr_rd_req), .xcr_index(xcr_index), .xcr_wr_req(xcr_wr_req),
      .xcr_wr_bits(xcr_wr_bits), .xcr_valid_r(xcr_valid_r), .xcr_acc_r(xcr_acc_r),
      .mem_rd_r(mem_rd_r), .mem_wr_r(mem_wr_r), .mem_addr_r(mem_addr_r),
      .mem_wdata_r(mem_wdata_r), .mem_wbe_r(mem_wbe_r), .mem_rvalid(mem_rvalid),
      .mem_rdata(mem_rdata));
   tme_mem_model mem (.clock(clock), .rst_n(rst_n), .slow(slow), .mem_rd_r(mem_rd_r),
      .mem_wr_r(mem_wr_r), .mem_addr_r(mem_addr_r), .mem_wdata_r(mem_wdata_r),
      .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));
   always #5 clock = ~clock;
   task automatic close_out();
      $display("compared %0d mismatched %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fails++;
         close_out();
      end
   end
   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   function automatic tme_cmd_t mk(input tme_op_t op, input logic [2:0] d,
      input logic [63:0] base, input logic [31:0] st, input logic [4:0] r,
      input logic [6:0] cb);
      return '{op, d, 3'h1, 3'h2, base, st, r, cb, DT_SS};
   endfunction
   function automatic logic [63:0] row8(input logic [7:0] b);
      for (int j = 0; j < 8; j++)
         row8[8*j +: 8] = b + 8'(j);
   endfunction
   task automatic run(input tme_cmd_t cm, input logic err, input int lat);
      int n;
      n = 0;
      do @(posedge clock); while (cmd_ready_r !== 1'b1);
      cmd <= cm;
      cmd_valid <= 1'b1;
      do
      begin
         @(posedge clock);
         n++;
      end while (rsp_done_r !== 1'b1 && n < 5000);
      cmd_valid <= 1'b0;
      check(64'(rsp_err_r), 64'(err));
      check(64'(err ? n <= 3 : n > lat), 64'h1);
   endtask
   task automatic cap_q(input logic [31:0] leaf);
      @(posedge clock);
      cap_req <= 1'b1;
      cap_leaf <= leaf;
      @(posedge clock);
      cap_req <= 1'b0;
      @(posedge clock);
   endtask
   task automatic xcr_q(input logic [31:0] idx);
      @(posedge clock);
      xcr_rd_req <= 1'b1;
      xcr_index <= idx;
      @(posedge clock);
      xcr_rd_req <= 1'b0;
      @(posedge clock);
      check(64'(xcr_valid_r), 64'h1);
   endtask
   task automatic xcr_w(input logic [1:0] b);
      @(posedge clock);
      xcr_wr_req <= 1'b1;
      xcr_wr_bits <= b;
      @(posedge clock);
      xcr_wr_req <= 1'b0;
   endtask
   task automatic st(input logic [2:0] t, output int kk);
      kk = mem.wn;
      run(mk(OP_STORE, t, 64'h1000, 32'h80, 5'h0, 7'h0), 1'b0, 16);
   endtask
   initial
   begin
      repeat (20) @(posedge clock);
      rst_n <= 1'b1;
      repeat (2) @(posedge clock);
      cap_q(32'h7);
      check(64'({cap_data_reg_r[25:24], cap_data_reg_r[22]}), 64'h7);
      cap_q(32'h1);
      check(64'(cap_count_reg_r[26]), 64'h1);
      $display("capability test finished");
      xcr_q(32'h0);
      check(64'(xcr_acc_r), 64'h0);
      run(mk(OP_ZERO, 3'h0, 64'h0, 32'h0, 5'h0, 7'h0), 1'b1, 0);
      xcr_w(2'h1);
      run(mk(OP_ZERO, 3'h0, 64'h0, 32'h0, 5'h0, 7'h0), 1'b1, 0);
      xcr_w(2'h3);
      xcr_q(32'h0);
      check(64'(xcr_acc_r), 64'h6_0000);
      xcr_q(32'h1);
      check(64'(xcr_acc_r), 64'h0);
      $display("enable test finished");
      for (int i = 0; i < 4; i++)
         run(mk(OP_LOAD_CFG, 3'h0, 64'h0, 32'h0, bad_r[i], bad_c[i]), 1'b1, 0);
      run(mk(OP_LOAD_CFG, 3'h4, 64'h0, 32'h0, 5'h10, 7'h40), 1'b0, 204);
      run(mk(OP_LOAD_CFG, 3'h0, 64'h0, 32'h0, 5'h2, 7'h8), 1'b0, 204);
      for (int i = 1; i < 4; i++)
         run(mk(OP_LOAD_CFG, 3'(i), 64'h0, 32'h0, 5'h1, 7'h4), 1'b0, 204);
      run(mk(OP_STORE_CFG, 3'h0, 64'h0, 32'h0, 5'h0, 7'h0), 1'b0, 19);
      check(64'({rsp_rows_r, rsp_colb_r}), 64'({5'h2, 7'h8}));
      $display("shape test finished");
      for (int i = 0; i < 2; i++)
      begin
         slow <= i[0];
         c = mk(i ? OP_LOAD_NT : OP_LOAD, 3'h0, 64'h104 + 64'(i), 32'h40, 5'h0, 7'h0);
         run(c, 1'b0, i ? 48 : 45);
         st(3'h0, k);
         for (int r = 0; r < 2; r++)
         begin
            check(mem.wa[k + r], 64'h1000 + 64'h80 * 64'(r));
            check(mem.wd[k + r], row8(8'h4 + 8'(i) + 8'h40 * 8'(r)));
         end
      end
      run(mk(OP_ZERO, 3'h0, 64'h0, 32'h0, 5'h0, 7'h0), 1'b0, 16);
      st(3'h0, k);
      check(mem.wd[k] | mem.wd[k + 1], 64'h0);
      $display("load store zero test finished");
      run(mk(OP_LOAD, 3'h1, 64'hfe, 32'h40, 5'h0, 7'h0), 1'b0, 45);
      run(mk(OP_LOAD, 3'h2, 64'h7e, 32'h40, 5'h0, 7'h0), 1'b0, 45);
      for (int i = 0; i < 5; i++)
      begin
         if (i == 4)
         begin
            run(mk(OP_LOAD, 3'h1, 64'h40, 32'h40, 5'h0, 7'h0), 1'b0, 45);
            run(mk(OP_LOAD, 3'h2, 64'h40, 32'h40, 5'h0, 7'h0), 1'b0, 45);
         end
         c = mk(OP_MUL, 3'h3, 64'h0, 32'h0, 5'h0, 7'h0);
         c.dtype = dts[i];
         run(mk(OP_ZERO, 3'h3, 64'h0, 32'h0, 5'h0, 7'h0), 1'b0, 16);
         run(c, 1'b0, 52);
         run(c, 1'b0, 52);
         st(3'h3, k);
         check(64'(mem.wd[k][31:0]), 64'(mul_exp[i]));
      end
      c.dtype = tme_dtype_t'(3'h5);
      run(c, 1'b1, 0);
      run(mk(OP_RELEASE, 3'h0, 64'h0, 32'h0, 5'h0, 7'h0), 1'b0, 13);
      run(mk(OP_LOAD, 3'h0, 64'h0, 32'h40, 5'h0, 7'h0), 1'b1, 0);
      $display("multiply test finished");
      close_out();
   end
endmodule // tme_top_bench
